// ### ttis_pkg.sv
// constants, types and event carrier for the time tag and event flag block
// assumes a single 10 MHz clock and an AHB-Lite master with word accesses
package ttis_pkg;

   // ***************************************************************
   // register map (word indexes, byte address is four times these)
   // ***************************************************************
   localparam logic [5:0] TIME_TAG_IDX = 6'h05;
   localparam logic [5:0] FLAGS_IDX = 6'h06;
   localparam logic [5:0] CONFIG_IDX = 6'h08;
   localparam logic [15:0] TIME_TAG_RESET = 16'h0000;
   localparam logic [15:0] FLAGS_RESET = 16'h0000;
   localparam logic [15:0] CONFIG_RESET = 16'h0000;

   // ***************************************************************
   // event flag positions
   // ***************************************************************
   localparam int MASTER_IRQ_BIT = 15;
   localparam int DOUBLE_BIT_MEM_FAULT_BIT = 14;
   localparam int TRANSMIT_TIMEOUT_BIT = 13;
   localparam int CMD_STACK_WRAP_BIT = 12;
   localparam int MONITOR_CMD_STACK_WRAP_BIT = 11;
   localparam int MONITOR_DATA_STACK_WRAP_BIT = 10;
   localparam int EXTERNAL_MEM_HANDSHAKE_FAIL_BIT = 9;
   localparam int CONTROLLER_RETRY_BIT = 8;
   localparam int TERMINAL_ADDR_PARITY_FAULT_BIT = 7;
   localparam int TAG_COUNTER_WRAP_BIT = 6;
   localparam int TERMINAL_RING_WRAP_BIT = 5;
   localparam int CONTROL_WORD_MSG_DONE_BIT = 4;
   localparam int CONTROLLER_FRAME_DONE_BIT = 3;
   localparam int MESSAGE_ERROR_BIT = 2;
   localparam int MODE_DEPENDENT_EVENT_BIT = 1;
   localparam int MESSAGE_DONE_BIT = 0;

   // ***************************************************************
   // configuration fields
   // ***************************************************************
   localparam int CFG_ENHANCED_IRQ_BIT = 15;
   localparam int CFG_DOUBLE_DETECT_BIT = 14;
   localparam int CFG_RESOLUTION_MSB = 9;
   localparam int CFG_RESOLUTION_LSB = 7;
   localparam int CFG_DOUBLE_FLAG_ENABLE_BIT = 0;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int CLOCK_PERIOD_NS = 100;
   localparam int MICROSECOND_NS = 1000;
   localparam int CYCLES_PER_US = MICROSECOND_NS / CLOCK_PERIOD_NS;

   // memory word: 16 data, 5 check bits, overall parity at the top
   localparam int ECC_WORD_W = 22;

   typedef enum logic [1:0] {
      MODE_BC = 2'h0,
      MODE_RT = 2'h1,
      MODE_ENHANCED_RT = 2'h2,
      MODE_WORD_MONITOR = 2'h3
   } ttis_mode_e;

   typedef enum logic [2:0] {
      PHASE_IDLE = 3'h1,
      PHASE_WRITE = 3'h2,
      PHASE_READ = 3'h4
   } ttis_phase_e;

   // one-cycle event strobes from the protocol engine
   typedef struct packed {
      logic irqDriven;
      logic transmitTimeout;
      logic cmdStackWrap;
      logic monitorCmdStackWrap;
      logic monitorDataStackWrap;
      logic externalMemHandshakeFail;
      logic controllerRetry;
      logic terminalRingWrap;
      logic messageDone;
      logic controlWordEomEnable;
      logic controllerFrameDone;
      logic messageError;
      logic statusWordMismatch;
      logic validModeCommand;
      logic validCommandWord;
      logic [15:0] commandWord;
   } ttis_events_s;

endpackage : ttis_pkg

// ### ttis_time_tag_status.sv
// time tag counter, first event flag register and memory ECC check
// assumes AHB-Lite as the only register path and one synchronous reset
//
// Functional notes
// R1: sixteen-bit read/write time tag, reset zero
// R2: tag resolution from three configuration bits
// R3: flags set regardless of interrupt enables
// R4: bit 15 on driven irq when enhanced
// R5: bit 14 on double-bit memory error, gated
// R6: single-bit memory errors corrected automatically
// R7: bit 13 on transmitter timeout
// R8: bit 12 on command stack rollover
// R9: bit 11 on monitor command stack rollover
// R10: bit 10 on monitor data stack rollover
// R11: bit 9 on transparent-mode handshake failure
// R12: bit 8 on every controller retry
// R13: bit 7 on terminal address parity fault
// R14: bit 6 on time tag wrap
// R15: bit 5 on terminal ring buffer wrap
// R16: bit 4 on enabled end of message
// R17: bit 3 on controller frame end
// R18: bit 2 on error, loopback, timeout
// R19: controller mode: bit 1 on status mismatch
// R20: enhanced terminal: bit 1 on mode command
// R21: word monitor: bit 1 on trigger match
// R22: bit 0 on every message end
// R23: tag wraps to zero, one-cycle event
module ttis_time_tag_status #(
   parameter int TAG_W = 16,
   parameter int RES_W = 3
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire ttis_pkg::ttis_events_s events,
   input wire ttis_pkg::ttis_mode_e mode,
   input wire logic transparentMode,
   input wire logic [4:0] terminalAddr,
   input wire logic terminalAddrParity,
   input wire logic [15:0] monitorTrigger,
   input wire logic memReadValid,
   input wire logic [ttis_pkg::ECC_WORD_W-1:0] memReadWord,
   output logic memDataValid,
   output logic [15:0] memData,
   output logic [15:0] eventFlags,
   output logic [15:0] configReg
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   // ***************************************************************
   // bus slave
   // ***************************************************************
   ttis_pkg::ttis_phase_e phase;
   ttis_pkg::ttis_phase_e next_phase;
   logic [5:0] dataIdx;
   logic addrTaken;
   logic statusRead;
   logic [31:0] next_hrdata;
   logic [TAG_W-1:0] tagCount;
   logic tagWrite;

   // decode only word-aligned addresses in the low page
   function automatic logic hits(input logic [31:0] a,
                                 input logic [5:0] idx);
      hits = (a[31:8] == 24'h000000) && (a[7:2] == idx) &&
             (a[1:0] == 2'h0);
   endfunction : hits

   assign addrTaken = hsel && htrans[1] && hready;
   assign statusRead = addrTaken && !hwrite &&
                       hits(haddr, ttis_pkg::FLAGS_IDX);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign tagWrite = (phase == ttis_pkg::PHASE_WRITE) &&
                     (dataIdx == ttis_pkg::TIME_TAG_IDX);

   always_comb begin
      next_phase = ttis_pkg::PHASE_IDLE;
      if (addrTaken && hwrite && hsize == 3'h2) begin
         next_phase = ttis_pkg::PHASE_WRITE;
      end else if (addrTaken && !hwrite) begin
         next_phase = ttis_pkg::PHASE_READ;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         phase <= ttis_pkg::PHASE_IDLE;
         dataIdx <= 6'h00;
      end else begin
         phase <= next_phase;
         dataIdx <= haddr[7:2];
         if (haddr[31:8] != 24'h000000 || haddr[1:0] != 2'h0) begin
            // unmapped: park on an index nothing decodes
            dataIdx <= 6'h3F;
         end
      end
   end

   // read data captured at the address edge, held through data phase
   always_comb begin
      next_hrdata = 32'h00000000;
      if (hits(haddr, ttis_pkg::TIME_TAG_IDX)) begin
         next_hrdata = {16'h0000, tagCount}; // R1
      end else if (hits(haddr, ttis_pkg::FLAGS_IDX)) begin
         next_hrdata = {16'h0000, eventFlags};
      end else if (hits(haddr, ttis_pkg::CONFIG_IDX)) begin
         next_hrdata = {16'h0000, configReg};
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         hrdata <= 32'h00000000;
      end else if (addrTaken && !hwrite) begin
         hrdata <= next_hrdata;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         configReg <= ttis_pkg::CONFIG_RESET;
      end else if (phase == ttis_pkg::PHASE_WRITE &&
                   dataIdx == ttis_pkg::CONFIG_IDX) begin
         configReg <= hwdata[15:0];
      end
   end

   // ***************************************************************
   // time tag
   // ***************************************************************
   logic [3:0] usCount;
   logic usTick;
   logic [7:0] resCount;
   logic [RES_W-1:0] resolution;
   logic [7:0] resLimit;
   logic tagTick;
   logic tagWrap;

   assign resolution = configReg[ttis_pkg::CFG_RESOLUTION_MSB:
                                 ttis_pkg::CFG_RESOLUTION_LSB];
   // 2^code microseconds per count
   assign resLimit = 8'((9'h001 << resolution) - 9'h001);
   assign usTick = usCount == 4'(ttis_pkg::CYCLES_PER_US - 1);
   assign tagTick = usTick && (resCount == resLimit); // R2
   assign tagWrap = tagTick && (tagCount == '1) && !tagWrite; // R23

   // prescalers restart on a tag write so the first count is full
   always_ff @(posedge clock) begin
      if (rst || tagWrite) begin
         usCount <= 4'h0;
      end else if (usTick) begin
         usCount <= 4'h0;
      end else begin
         usCount <= usCount + 4'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || tagWrite) begin
         resCount <= 8'h00;
      end else if (tagTick || (usTick && resCount >= resLimit)) begin
         resCount <= 8'h00; // R2
      end else if (usTick) begin
         resCount <= resCount + 8'h01;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         tagCount <= TAG_W'(ttis_pkg::TIME_TAG_RESET); // R1
      end else if (tagWrite) begin
         tagCount <= hwdata[TAG_W-1:0]; // R1
      end else if (tagTick) begin
         tagCount <= tagCount + TAG_W'(1); // R23
      end
   end

   // ***************************************************************
   // memory error correction
   // ***************************************************************
   logic doubleFault;

   // returns {double error, corrected data}
   function automatic logic [16:0] eccCheck(
         input logic [ttis_pkg::ECC_WORD_W-1:0] w);
      logic [4:0] syn;
      logic odd;
      logic [20:0] fixed;
      logic [15:0] data;
      int k;
      syn = 5'h00;
      odd = ^w;
      fixed = w[20:0];
      data = 16'h0000;
      k = 0;
      for (int p = 1; p <= 21; p++) begin
         if (w[p-1]) begin
            syn = syn ^ 5'(p);
         end
      end
      if (odd && syn != 5'h00 && syn <= 5'h15) begin
         fixed[syn-5'h01] = !fixed[syn-5'h01];
      end
      for (int p = 1; p <= 21; p++) begin
         if ((p & (p - 1)) != 0) begin
            data[k] = fixed[p-1];
            k = k + 1;
         end
      end
      eccCheck = {!odd && syn != 5'h00, data};
   endfunction : eccCheck

   always_ff @(posedge clock) begin
      if (rst) begin
         memDataValid <= 1'b0;
         memData <= 16'h0000;
         doubleFault <= 1'b0;
      end else begin
         memDataValid <= memReadValid;
         doubleFault <= 1'b0;
         if (memReadValid) begin
            {doubleFault, memData} <= eccCheck(memReadWord); // R6
         end
      end
   end

   // ***************************************************************
   // event flags
   // ***************************************************************
   logic [15:0] setVec;
   logic parityFault;
   logic modeEvent;

   assign parityFault = !(^{terminalAddr, terminalAddrParity});

   always_comb begin
      case (mode)
         ttis_pkg::MODE_BC: modeEvent = events.statusWordMismatch; // R19
         ttis_pkg::MODE_ENHANCED_RT:
            modeEvent = events.validModeCommand; // R20
         ttis_pkg::MODE_WORD_MONITOR:
            modeEvent = events.validCommandWord &&
                        events.commandWord == monitorTrigger; // R21
         default: modeEvent = 1'b0;
      endcase
   end

   // no enable gates these except where a condition names one
   always_comb begin
      setVec = 16'h0000; // R3
      setVec[ttis_pkg::MASTER_IRQ_BIT] = events.irqDriven &&
         configReg[ttis_pkg::CFG_ENHANCED_IRQ_BIT]; // R4
      setVec[ttis_pkg::DOUBLE_BIT_MEM_FAULT_BIT] = doubleFault &&
         configReg[ttis_pkg::CFG_DOUBLE_DETECT_BIT] &&
         configReg[ttis_pkg::CFG_DOUBLE_FLAG_ENABLE_BIT]; // R5
      setVec[ttis_pkg::TRANSMIT_TIMEOUT_BIT] =
         events.transmitTimeout; // R7
      setVec[ttis_pkg::CMD_STACK_WRAP_BIT] = events.cmdStackWrap; // R8
      setVec[ttis_pkg::MONITOR_CMD_STACK_WRAP_BIT] =
         events.monitorCmdStackWrap; // R9
      setVec[ttis_pkg::MONITOR_DATA_STACK_WRAP_BIT] =
         events.monitorDataStackWrap; // R10
      setVec[ttis_pkg::EXTERNAL_MEM_HANDSHAKE_FAIL_BIT] =
         events.externalMemHandshakeFail && transparentMode; // R11
      setVec[ttis_pkg::CONTROLLER_RETRY_BIT] =
         events.controllerRetry; // R12
      setVec[ttis_pkg::TERMINAL_ADDR_PARITY_FAULT_BIT] =
         parityFault; // R13
      setVec[ttis_pkg::TAG_COUNTER_WRAP_BIT] = tagWrap; // R14
      setVec[ttis_pkg::TERMINAL_RING_WRAP_BIT] =
         events.terminalRingWrap; // R15
      setVec[ttis_pkg::CONTROL_WORD_MSG_DONE_BIT] = events.messageDone &&
         events.controlWordEomEnable; // R16
      setVec[ttis_pkg::CONTROLLER_FRAME_DONE_BIT] =
         events.controllerFrameDone; // R17
      setVec[ttis_pkg::MESSAGE_ERROR_BIT] = events.messageError; // R18
      setVec[ttis_pkg::MODE_DEPENDENT_EVENT_BIT] = modeEvent;
      setVec[ttis_pkg::MESSAGE_DONE_BIT] = events.messageDone; // R22
   end

   // read clears, but an event in the read cycle survives it
   always_ff @(posedge clock) begin
      if (rst) begin
         eventFlags <= ttis_pkg::FLAGS_RESET;
      end else if (statusRead) begin
         eventFlags <= setVec; // R3
      end else begin
         eventFlags <= eventFlags | setVec; // R3
      end
   end

   // ***************************************************************
   // checks
   // ***************************************************************

   tagAdvance_a: assert property ( // R1
      tagTick && !tagWrite |=> tagCount == $past(tagCount) + 16'h0001)
      else $error("time tag did not advance on its tick");

   tagLoad_a: assert property ( // R1
      tagWrite |=> tagCount == $past(hwdata[15:0]))
      else $error("time tag write not taken");

   tickGap_a: assert property ( // R2
      tagTick && resolution == 3'h0 ##1 (!tagWrite && resolution == 3'h0)
      [*8] ##1 (!tagWrite && resolution == 3'h0) [*2] |-> tagTick)
      else $error("one microsecond tick spacing wrong");

   tagWrap_a: assert property ( // R23
      tagWrap |=> tagCount == 16'h0000 &&
                  eventFlags[ttis_pkg::TAG_COUNTER_WRAP_BIT])
      else $error("time tag wrap did not zero and flag");

   flagsSticky_a: assert property ( // R3
      !statusRead |=> (eventFlags & $past(eventFlags)) ==
                      $past(eventFlags))
      else $error("event flag dropped without a read");

   readClear_a: assert property ( // R3
      statusRead && setVec == 16'h0000 |=> eventFlags == 16'h0000)
      else $error("status read did not clear flags");

   masterIrq_a: assert property ( // R4
      events.irqDriven && configReg[ttis_pkg::CFG_ENHANCED_IRQ_BIT] |=>
      eventFlags[ttis_pkg::MASTER_IRQ_BIT])
      else $error("driven irq not flagged in enhanced mode");

   doubleFault_a: assert property ( // R5
      memReadValid ##1 doubleFault && configReg[15:14] == 2'h1 &&
      configReg[0] |=> eventFlags[ttis_pkg::DOUBLE_BIT_MEM_FAULT_BIT])
      else $error("double-bit memory error not flagged");

   parityFlag_a: assert property ( // R13
      parityFault |=> eventFlags[ttis_pkg::TERMINAL_ADDR_PARITY_FAULT_BIT])
      else $error("terminal address parity fault not flagged");

   eomBoth_a: assert property ( // R16
      events.messageDone && events.controlWordEomEnable |=>
      eventFlags[ttis_pkg::CONTROL_WORD_MSG_DONE_BIT] &&
      eventFlags[ttis_pkg::MESSAGE_DONE_BIT])
      else $error("end of message flags not both set");

   triggerMatch_a: assert property ( // R21
      mode == ttis_pkg::MODE_WORD_MONITOR && events.validCommandWord &&
      events.commandWord == monitorTrigger |=>
      eventFlags[ttis_pkg::MODE_DEPENDENT_EVENT_BIT])
      else $error("monitor trigger match not flagged");

   wrapSeen_c: cover property (tagWrap);
   clearRace_c: cover property (statusRead && setVec != 16'h0000);
   doubleSeen_c: cover property (
      doubleFault && configReg[ttis_pkg::CFG_DOUBLE_DETECT_BIT]);
   tagWritten_c: cover property (tagWrite ##1 tagTick);

endmodule : ttis_time_tag_status

// ### ttis_host_model.sv
// host processor model: AHB-Lite master doing single word transfers
// assumes hready is the slave's hreadyout; hung flags a dead wait
module ttis_host_model (
   input wire logic clock,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   output logic hung
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      hung = 1'b0;
   end

   // bounded: a stuck slave must end the run, not hang it
   task automatic waitReady;
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1) hung = 1'b1;
   endtask : waitReady

   task automatic addrPhase(input logic [31:0] a, input logic w);
      @(posedge clock);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      waitReady();
      hsel <= 1'b0;
      htrans <= 2'h0;
      // the released address never keeps the last value; hwrite and hsize do
      haddr <= ~a;
   endtask : addrPhase

   task automatic write(input logic [31:0] a, input logic [31:0] d);
      addrPhase(a, 1'b1);
      hwdata <= d;
      waitReady();
      hwdata <= ~d;
   endtask : write

   task automatic read(input logic [31:0] a, output logic [31:0] d);
      addrPhase(a, 1'b0);
      waitReady();
      d = hrdata;
   endtask : read

endmodule : ttis_host_model

// ### tb_time_tag_and_interrupt_status.sv
// self-checking bench for the time tag and event flag block
// assumes the host model as the only bus master, 10 MHz clock
module tb_time_tag_and_interrupt_status;
   timeunit 1ns;
   timeprecision 1ns;

   // ***************************************************************
   // signals and tables
   // ***************************************************************
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic hsel, hwrite, hresp, hreadyout, hung;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   ttis_pkg::ttis_events_s events = '0;
   ttis_pkg::ttis_mode_e mode = ttis_pkg::MODE_BC;
   logic transparentMode = 1'b1;
   logic [4:0] terminalAddr = 5'h00;
   logic terminalAddrParity = 1'b1;
   logic [15:0] monitorTrigger = 16'h0000;
   logic memReadValid = 1'b0;
   logic [21:0] memReadWord = 22'h0;
   logic memDataValid;
   logic [15:0] memData, eventFlags, cfgOut;
   int mismatches = 0;
   int checked = 0;
   // strobe vector, expected flags and mode for each event case
   logic [30:0] evTab [18] = '{31'h40000000, 31'h20000000, 31'h10000000,
      31'h10000000, 31'h08000000, 31'h04000000, 31'h02000000, 31'h01000000,
      31'h00800000, 31'h00600000, 31'h00400000, 31'h00100000, 31'h00080000,
      31'h00040000, 31'h00020000, 31'h00010000, 31'h00010000, 31'h00020000};
   logic [15:0] xTab [18] = '{16'h8000, 16'h2000, 16'h1000, 16'h1000,
      16'h0800, 16'h0400, 16'h0200, 16'h0100, 16'h0020, 16'h0011, 16'h0001,
      16'h0008, 16'h0004, 16'h0002, 16'h0002, 16'h0002, 16'h0000, 16'h0000};
   logic [1:0] mdTab [18] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0,
      2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h3, 2'h3, 2'h1};

   always #50 clock = ~clock;

   ttis_time_tag_status uut (
      .clock(clock),
      .rst(rst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hreadyout),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .events(events),
      .mode(mode),
      .transparentMode(transparentMode),
      .terminalAddr(terminalAddr),
      .terminalAddrParity(terminalAddrParity),
      .monitorTrigger(monitorTrigger),
      .memReadValid(memReadValid),
      .memReadWord(memReadWord),
      .memDataValid(memDataValid),
      .memData(memData),
      .eventFlags(eventFlags),
      .configReg(cfgOut)
   );

   ttis_host_model host (
      .clock(clock),
      .hready(hreadyout),
      .hrdata(hrdata),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hung(hung)
   );

   // ***************************************************************
   // checking helpers
   // ***************************************************************
   task automatic conclude;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] d;
      host.read(a, d);
      chk(d, exp);
   endtask : rd

   task automatic pulse(input logic [30:0] ev);
      events <= ttis_pkg::ttis_events_s'(ev);
      @(posedge clock);
      events <= '0;
   endtask : pulse

   // sixteen data bits into positions 1..21, even check bits, top parity
   function automatic logic [21:0] enc(input logic [15:0] d);
      logic [21:0] w;
      int p, j, k;
      w = 22'h0;
      k = 0;
      for (p = 1; p <= 21; p++) begin
         if ((p & (p - 1)) != 0) begin
            w[p-1] = d[k];
            k++;
         end
      end
      for (j = 0; j < 5; j++)
         for (p = 1; p <= 21; p++)
            if (((p >> j) & 1) == 1 && p != (1 << j))
               w[(1 << j) - 1] ^= w[p-1];
      w[21] = ^w[20:0];
      return w;
   endfunction : enc

   task automatic memChk(input logic [21:0] w, input logic [15:0] d,
                         input logic good);
      @(posedge clock);
      memReadValid <= 1'b1;
      memReadWord <= w;
      @(posedge clock);
      memReadValid <= 1'b0;
      memReadWord <= ~w;
      #1;
      chk({31'h0, memDataValid}, 32'h1);
      if (good) chk({16'h0, memData}, {16'h0, d});
   endtask : memChk

   always @(posedge hung) begin
      mismatches++;
      conclude();
   end

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      logic [31:0] d;
      logic [30:0] ev;
      logic [21:0] w;
      logic [15:0] v;
      int i, r, k, p, b;
      void'($urandom(32'hD3F91A0F));
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      rd(32'h14, 32'h0);
      rd(32'h18, 32'h0);
      rd(32'h20, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      // status is read-only, holes read zero
      host.write(32'h18, 32'hFFFF);
      rd(32'h18, 32'h0);
      rd(32'h40, 32'h0);
      v = 16'($urandom);
      host.write(32'h20, {16'h0, v});
      rd(32'h20, {16'h0, v});
      chk({16'h0, cfgOut}, {16'h0, v});
      monitorTrigger <= 16'($urandom);
      host.write(32'h20, 32'h8000);
      host.read(32'h18, d);
      for (i = 0; i < 18; i++) begin
         ev = evTab[i];
         ev[15:0] = (i == 16) ? ~monitorTrigger : monitorTrigger;
         mode <= ttis_pkg::ttis_mode_e'(mdTab[i]);
         pulse(ev);
         #1;
         chk({16'h0, eventFlags}, {16'h0, xTab[i]});
         rd(32'h18, {16'h0, xTab[i]});
      end
      host.write(32'h20, 32'h0);
      pulse(31'h40000000);
      rd(32'h18, 32'h0);
      // handshake failures only count in transparent mode
      transparentMode <= 1'b0;
      pulse(31'h02000000);
      rd(32'h18, 32'h0);
      transparentMode <= 1'b1;
      v = 16'($urandom);
      terminalAddr <= v[4:0];
      terminalAddrParity <= ^v[4:0];
      repeat (3) @(posedge clock);
      terminalAddr <= 5'h00;
      terminalAddrParity <= 1'b1;
      repeat (2) @(posedge clock);
      rd(32'h18, 32'h80);
      rd(32'h18, 32'h0);
      // first pass forces a wrap from all ones
      for (i = 0; i < 4; i++) begin
         r = $urandom_range(2);
         k = (i == 0) ? 1 : $urandom_range(3, 1);
         v = (i == 0) ? 16'hFFFF : 16'($urandom_range(16'hFFF0));
         p = 10 << r;
         host.write(32'h20, {22'h0, 3'(r), 7'h0});
         host.read(32'h18, d);
         host.write(32'h14, {16'h0, v});
         repeat (k * p + p / 2 - 2) @(posedge clock);
         rd(32'h14, {16'h0, v + 16'(k)});
         rd(32'h18, (i == 0) ? 32'h40 : 32'h0);
      end
      for (i = 0; i < 6; i++) begin
         host.write(32'h20, (i < 3) ? 32'h4001 :
                    (i == 3) ? 32'h4000 : 32'h0001);
         v = 16'($urandom);
         w = enc(v);
         b = $urandom_range(21);
         host.read(32'h18, d);
         memChk(w ^ (22'h1 << b), v, 1'b1);
         rd(32'h18, 32'h0);
         k = (b + $urandom_range(21, 1)) % 22;
         memChk(w ^ (22'h1 << b) ^ (22'h1 << k), v, 1'b0);
         rd(32'h18, (i < 3) ? 32'h4000 : 32'h0);
      end
      conclude();
   end

endmodule : tb_time_tag_and_interrupt_status
